// [src/ips_ctrl.sv]
// Interrupt priority and service controller with APB register access
// ==========================================================
//
// Local design decision: the APB interface to the registers.
module ips_ctrl
(
	input  wire logic                pclk,       // System clock
	input  wire logic                presetn,    // Async reset, low
	input  wire logic                psel,       // APB select
	input  wire logic                penable,    // APB enable
	input  wire logic                pwrite,     // APB direction
	input  wire logic [11:0]         paddr,      // APB byte address
	input  wire logic [31:0]         pwdata,     // APB write data
	output logic                     pready,     // APB ready
	output logic [31:0]              prdata,     // APB read data
	output logic                     pslverr,    // APB error
	input  wire ips_pkg::ips_req_t   req,        // Sequencer request
	output ips_pkg::ips_call_t       call_out,   // Call to sequencer
	output logic [3:0]               in_service  // Per-level busy flags
);

	// ==========================================================
	// State record
	typedef struct packed {
		logic [7:0]            hi_base;
		logic [7:0]            lo_base;
		logic [7:0]            lo_ext;
		logic [7:0]            hi_ext;
		logic [7:0]            lo_ext2;
		logic [7:0]            hi_ext2;
		logic [3:0]            busy;
		ips_pkg::ips_state_t   state;
		logic [2:0]            cnt;
		ips_pkg::ips_call_t    call;
		logic                  ready;
		logic [31:0]           rdata;
		logic                  err;
	} ips_regs_t;

	ips_regs_t state_reg;
	ips_regs_t state_next;

	logic [ips_pkg::NUM_SRC-1:0] lo_bits;
	logic [ips_pkg::NUM_SRC-1:0] hi_bits;
	logic                        win_found;
	logic [4:0]                  win_src;
	logic [1:0]                  win_level;
	logic                        grant;
	logic                        apb_acc;

	// ==========================================================
	// True when a level equal to or above lvl is in service
	function automatic logic blocks(input logic [3:0] busy,
		input logic [1:0] lvl);
		logic b;
		b = 1'b0;
		for (int l = 0; l < ips_pkg::NUM_LVL; l++)
		begin
			if (busy[l] && l >= int'(lvl))
				b = 1'b1;
		end
		return b;
	endfunction : blocks

	// Clear the highest set in-service bit
	function automatic logic [3:0] pop_top(input logic [3:0] busy);
		logic [3:0] r;
		logic       done;
		r    = busy;
		done = 1'b0;
		for (int l = ips_pkg::NUM_LVL - 1; l >= 0; l--)
		begin
			if (r[l] && !done)
			begin
				r[l] = 1'b0;
				done = 1'b1;
			end
		end
		return r;
	endfunction : pop_top

	// Masked register read, upper bits zero
	function automatic logic [31:0] rd8(input logic [7:0] v,
		input logic [7:0] m);
		return {24'h000000, v & m};
	endfunction : rd8

	// Masked register write; bits with no source behind them stay zero
	function automatic logic [7:0] wr8(input logic [31:0] d,
		input logic [7:0] m);
		return d[7:0] & m;
	endfunction : wr8

	// ==========================================================
	// Flatten priority bits into per-source vectors
	assign lo_bits = {state_reg.lo_ext2[2:0], state_reg.lo_ext,
		state_reg.lo_base[6:0]};
	assign hi_bits = {state_reg.hi_ext2[2:0], state_reg.hi_ext,
		state_reg.hi_base[6:0]};

	// Combinational resolve of the raw flags, no latching of them
	ips_resolve u_resolve
	(
		.flags   (req.flags),
		.lo_bits (lo_bits),
		.hi_bits (hi_bits),
		.found   (win_found),
		.src     (win_src),
		.level   (win_level)
	);

	// Grant gating; a call already in flight also blocks, so the
	// sequencer never sees two overlapping hardware calls
	assign grant = win_found
		&& req.last_cyc
		&& !req.prio_wr && !req.return_from_interrupt
		&& !blocks(state_reg.busy, win_level)
		&& state_reg.state == ips_pkg::IPS_IDLE;

	assign apb_acc = psel && penable && !state_reg.ready;

	// ==========================================================
	// Next-state logic
	always_comb
	begin
		state_next            = state_reg;
		state_next.call.start = 1'b0;
		state_next.ready      = 1'b0;
		state_next.err        = 1'b0;

		// Service sequence: four-cycle call, one return cycle, then idle
		case (state_reg.state)
			ips_pkg::IPS_IDLE:
			begin
				if (grant)
				begin
					// Sequencer pushes PC only and loads the vector
					state_next.state      = ips_pkg::IPS_CALL;
					state_next.cnt        = 3'h0;
					state_next.call.call  = 1'b1;
					state_next.call.start = 1'b1;
					state_next.call.src   = win_src;
					state_next.call.level = win_level;
					state_next.busy[win_level] = 1'b1;
				end
			end
			ips_pkg::IPS_CALL:
			begin
				if (state_reg.cnt == ips_pkg::CALL_LAST)
				begin
					state_next.state     = ips_pkg::IPS_RET;
					state_next.call.call = 1'b0;
				end
				else
					state_next.cnt = state_reg.cnt + 3'h1;
			end
			ips_pkg::IPS_RET:
				state_next.state = ips_pkg::IPS_IDLE;
			default:
				state_next.state = ips_pkg::IPS_IDLE;
		endcase

		// Return pops in-service; plain return and stack content ignored
		if (req.return_from_interrupt && req.last_cyc)
			state_next.busy = pop_top(state_reg.busy);

		// APB slave, one wait state, flags are never cleared here
		if (apb_acc)
		begin
			state_next.ready = 1'b1;
			state_next.rdata = 32'h00000000;
			case (paddr)
				// Base high: bit 7 has no source behind it
				ips_pkg::ADDR_PRIO_HIGH_BASE:
				begin
					if (pwrite)
						state_next.hi_base = wr8(pwdata, ips_pkg::MASK_BASE);
					else
						state_next.rdata = rd8(state_reg.hi_base,
							ips_pkg::MASK_BASE);
				end
				// Base low: same layout as base high
				ips_pkg::ADDR_PRIO_LOW_BASE:
				begin
					if (pwrite)
						state_next.lo_base = wr8(pwdata, ips_pkg::MASK_BASE);
					else
						state_next.rdata = rd8(state_reg.lo_base,
							ips_pkg::MASK_BASE);
				end
				// Extended low: all eight bits in use
				ips_pkg::ADDR_PRIO_LOW_EXT:
				begin
					if (pwrite)
						state_next.lo_ext = wr8(pwdata, ips_pkg::MASK_EXT);
					else
						state_next.rdata = rd8(state_reg.lo_ext,
							ips_pkg::MASK_EXT);
				end
				// Extended high: pairs bit for bit with extended low
				ips_pkg::ADDR_PRIO_HIGH_EXT:
				begin
					if (pwrite)
						state_next.hi_ext = wr8(pwdata, ips_pkg::MASK_EXT);
					else
						state_next.rdata = rd8(state_reg.hi_ext,
							ips_pkg::MASK_EXT);
				end
				// Second extended low: only three sources
				ips_pkg::ADDR_PRIO_LOW_EXT2:
				begin
					if (pwrite)
						state_next.lo_ext2 = wr8(pwdata, ips_pkg::MASK_EXT2);
					else
						state_next.rdata = rd8(state_reg.lo_ext2,
							ips_pkg::MASK_EXT2);
				end
				// Second extended high: same three sources
				ips_pkg::ADDR_PRIO_HIGH_EXT2:
				begin
					if (pwrite)
						state_next.hi_ext2 = wr8(pwdata, ips_pkg::MASK_EXT2);
					else
						state_next.rdata = rd8(state_reg.hi_ext2,
							ips_pkg::MASK_EXT2);
				end
				// Status is read-only; a write is refused with an error
				ips_pkg::ADDR_SERVICE_STATUS:
				begin
					if (pwrite)
						state_next.err = 1'b1;
					else
						state_next.rdata = {25'h0, state_reg.call.call,
							state_reg.state, state_reg.busy};
				end
				// Unmapped offsets answer with an error and change nothing
				default:
					state_next.err = 1'b1;
			endcase
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg         <= '0;
			state_reg.hi_base <= ips_pkg::PRIO_RESET;
			state_reg.lo_base <= ips_pkg::PRIO_RESET;
			state_reg.state   <= ips_pkg::IPS_IDLE;
		end
		else
			state_reg <= state_next;
	end

	// ==========================================================
	// Outputs straight from flops
	assign pready     = state_reg.ready;
	assign prdata     = state_reg.rdata;
	assign pslverr    = state_reg.err;
	assign call_out   = state_reg.call;
	assign in_service = state_reg.busy;

endmodule : ips_ctrl

// [shared/ips_pkg.sv]
// Package: register map, source numbering and carrier structs
package ips_pkg;

	// ==========================================================
	// Register byte addresses (APB, one aligned word each)
	localparam logic [11:0] ADDR_PRIO_HIGH_BASE  = 12'h0b7 * 12'h004;
	localparam logic [11:0] ADDR_PRIO_LOW_BASE   = 12'h0b8 * 12'h004;
	localparam logic [11:0] ADDR_PRIO_LOW_EXT    = 12'h0ef * 12'h004;
	localparam logic [11:0] ADDR_PRIO_HIGH_EXT   = 12'h0f7 * 12'h004;
	localparam logic [11:0] ADDR_PRIO_LOW_EXT2   = 12'h0fe * 12'h004;
	localparam logic [11:0] ADDR_PRIO_HIGH_EXT2  = 12'h0ff * 12'h004;
	localparam logic [11:0] ADDR_SERVICE_STATUS  = 12'h100 * 12'h004;

	// ==========================================================
	// Writable bit masks and reset values
	localparam logic [7:0] MASK_BASE  = 8'h7f;
	localparam logic [7:0] MASK_EXT   = 8'hff;
	localparam logic [7:0] MASK_EXT2  = 8'h07;
	localparam logic [7:0] PRIO_RESET = 8'h00;

	// ==========================================================
	// Sources and timing
	localparam int NUM_SRC     = 18;
	localparam int NUM_LVL     = 4;
	localparam int CALL_CYCLES = 4;
	localparam logic [2:0] CALL_LAST = 3'(CALL_CYCLES - 1);

	// Bit positions of the priority registers in the flattened source
	// vector: 0..6 base, 7..14 extended, 15..17 second extended
	localparam int SRC_BASE_LSB = 0;
	localparam int SRC_EXT_LSB  = 7;
	localparam int SRC_EXT2_LSB = 15;

	// Natural order, highest first, by flattened source index
	localparam logic [4:0] NAT_ORDER [NUM_SRC] = '{
		5'd0,  5'd5,  5'd11, 5'd1,  5'd7,  5'd6,  5'd2,  5'd8,  5'd3,
		5'd4,  5'd12, 5'd13, 5'd14, 5'd9,  5'd10, 5'd15, 5'd16, 5'd17};

	typedef enum logic [1:0] {
		IPS_IDLE = 2'b00,
		IPS_CALL = 2'b01,
		IPS_RET  = 2'b11
	} ips_state_t;

	// Request carrier from the sequencer
	typedef struct packed {
		logic [NUM_SRC-1:0] flags;     // Raw interrupt flags
		logic               last_cyc;  // Final cycle of instruction
		logic               prio_wr;   // Instruction writes enable/prio
		logic               return_from_interrupt;      // Return from interrupt
	} ips_req_t;

	// Call carrier to the sequencer
	typedef struct packed {
		logic       call;    // Vectored call in progress
		logic       start;   // First cycle of the call
		logic [4:0] src;     // Source being vectored
		logic [1:0] level;   // Its level
	} ips_call_t;

endpackage : ips_pkg

// [src/ips_resolve.sv]
// Priority resolver: picks the winning pending source
module ips_resolve
(
	input  wire logic [ips_pkg::NUM_SRC-1:0] flags,   // Sampled flags
	input  wire logic [ips_pkg::NUM_SRC-1:0] lo_bits, // Low priority bits
	input  wire logic [ips_pkg::NUM_SRC-1:0] hi_bits, // High priority bits
	output logic                             found,   // Any pending
	output logic [4:0]                       src,     // Winner index
	output logic [1:0]                       level    // Winner level
);

	// ==========================================================
	// Scan in natural order; strict compare keeps the earlier one
	always_comb
	begin
		logic [4:0] idx;
		logic [1:0] lvl;
		idx   = 5'h00;
		lvl   = 2'h0;
		found = 1'b0;
		src   = 5'h00;
		level = 2'h0;
		for (int i = 0; i < ips_pkg::NUM_SRC; i++)
		begin
			idx = ips_pkg::NAT_ORDER[i];
			lvl = {hi_bits[idx], lo_bits[idx]};
			if (flags[idx] && (!found || lvl > level))
			begin
				found = 1'b1;
				src   = idx;
				level = lvl;
			end
		end
	end

endmodule : ips_resolve

// [sim/ips_ctrl_sva.sv]
// Checker: call timing and in-service nesting of the controller
module ips_ctrl_sva
(
	input wire logic               pclk,       // System clock
	input wire logic               presetn,    // Async reset, low
	input wire ips_pkg::ips_req_t  req,        // Sequencer request
	input wire ips_pkg::ips_call_t call_out,   // Call to sequencer
	input wire logic [3:0]         in_service  // Per-level busy
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] drop;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ==========================================================
	// Helper: busy flags once the top level is retired
	always_comb
	begin
		drop = 4'h0;
		if (in_service[3])
			drop = {1'b0, in_service[2:0]};
		else if (in_service[2])
			drop = {2'b0, in_service[1:0]};
		else if (in_service[1])
			drop = {3'b0, in_service[0]};
	end
	// ==========================================================
	// Properties
	a_call_four: assert property ($rose(call_out.call) |->
		call_out.call[*4] ##1 !call_out.call)
		else $error("call length wrong");
	a_start_first: assert property (call_out.start |->
		call_out.call && !$past(call_out.call))
		else $error("start not on first call cycle");
	a_need_last: assert property (call_out.start |->
		$past(req.last_cyc))
		else $error("call without instruction end");
	a_no_write_return: assert property (call_out.start |->
		!$past(req.prio_wr) && !$past(req.return_from_interrupt))
		else $error("call after write or return");
	a_fresh_poll: assert property (call_out.start |->
		(($past(req.flags) >> call_out.src) & 18'h1) != 18'h0)
		else $error("call for inactive flag");
	a_busy_set: assert property (call_out.start |->
		in_service[call_out.level])
		else $error("level not marked busy");
	a_no_equal: assert property (call_out.start |->
		($past(in_service) >> call_out.level) == 4'h0)
		else $error("call over equal or higher level");
	a_top_clear: assert property (req.return_from_interrupt && req.last_cyc |=>
		in_service == $past(drop))
		else $error("return cleared wrong level");
	a_busy_hold: assert property (!call_out.start &&
		!($past(req.return_from_interrupt) && $past(req.last_cyc)) |->
		$stable(in_service))
		else $error("busy flags moved without cause");
endmodule : ips_ctrl_sva

bind ips_ctrl ips_ctrl_sva chk (.pclk(pclk), .presetn(presetn), .req(req),
	.call_out(call_out), .in_service(in_service));

// [sim/ips_seq_model.sv]
// Sequencer model: marks instruction ends towards the controller
module ips_seq_model
(
	input  wire logic               pclk,      // System clock
	input  wire logic               presetn,   // Async reset, low
	input  wire logic [17:0]        flags,     // Flags to present
	input  wire logic               fire,      // Instruction ends
	input  wire logic               wr_prio,   // It writes priority
	input  wire logic               do_return, // It is a return
	input  wire ips_pkg::ips_call_t call_out,  // Call from controller
	output ips_pkg::ips_req_t       req        // Request out
);
	timeunit 1ns;
	timeprecision 1ps;
	// The hardware call is an instruction itself, so no end mark
	// is given while it runs
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			req <= '0;
		else
		begin
			req.flags <= flags;
			req.last_cyc <= fire & ~call_out.call;
			req.prio_wr <= wr_prio;
			req.return_from_interrupt <= do_return & fire;
		end
endmodule : ips_seq_model

// [sim/interrupt_priority_service_bench.sv]
// Bench: registers, arbitration and nesting of the controller
module interrupt_priority_service_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic               pclk, presetn, psel, penable, pwrite;
	logic               pready, pslverr, fire, wr_prio, do_return;
	logic [11:0]        paddr;
	logic [31:0]        pwdata, prdata;
	logic [17:0]        flags, lo, hi, f;
	logic [15:0]        lfsr;
	logic [3:0]         in_service;
	ips_pkg::ips_req_t  req;
	ips_pkg::ips_call_t call_out;
	logic [31:0]        rdq [$];
	logic [6:0]         cq [$];
	int                 mismatches, tests_run, cycles;
	localparam logic [11:0] ADR [6] = '{ips_pkg::ADDR_PRIO_HIGH_BASE,
		ips_pkg::ADDR_PRIO_LOW_BASE, ips_pkg::ADDR_PRIO_LOW_EXT,
		ips_pkg::ADDR_PRIO_HIGH_EXT, ips_pkg::ADDR_PRIO_LOW_EXT2,
		ips_pkg::ADDR_PRIO_HIGH_EXT2};
	localparam logic [7:0] MSK [6] = '{8'h7f, 8'h7f, 8'hff, 8'hff,
		8'h07, 8'h07};

	ips_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .req(req), .call_out(call_out),
		.in_service(in_service));
	ips_seq_model seq (.pclk(pclk), .presetn(presetn), .flags(flags),
		.fire(fire), .wr_prio(wr_prio), .do_return(do_return),
		.call_out(call_out), .req(req));

	// ==========================================================
	// Clock, timeout and result monitor
	initial
	begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	// Cycle ceiling; a hang ends in the same verdict as a mismatch
	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 8000)
		begin
			mismatches++;
			summarize();
		end
	end
	// Each result met takes the oldest note; none queued means x
	always @(posedge pclk)
	begin
		if (pready && !pwrite && !pslverr)
			check(prdata, rdq.size() ? rdq.pop_front() : 'x,
				"rd");
		if (call_out.start)
			check(32'({call_out.src, call_out.level}),
				cq.size() ? 32'(cq.pop_front()) : 'x, "call");
	end

	// ==========================================================
	// Tasks
	task automatic check(input logic [31:0] seen, exp, input string n);
		tests_run++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[FAIL] %s exp %h seen %h", n, exp, seen);
		end
	endtask : check
	// Entered at an edge; one idle cycle after, so psel never
	// gets two assignments in one step
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, input logic e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		check(32'(pslverr), 32'(e), "err");
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic setp(input logic [17:0] l, h);
		logic [7:0] v [6];
		v = '{{1'b0, h[6:0]}, {1'b0, l[6:0]}, l[14:7], h[14:7],
			{5'h0, l[17:15]}, {5'h0, h[17:15]}};
		lo = l;
		hi = h;
		for (int i = 0; i < 6; i++)
			apb(1'b1, ADR[i], {24'h0, v[i]}, 1'b0);
	endtask : setp
	// One instruction end; the wait covers call plus settle time
	task automatic poll(input logic [17:0] fl, input logic lc, w, r,
		go, input logic [6:0] e);
		if (go)
			cq.push_back(e);
		flags <= fl;
		fire <= lc;
		wr_prio <= w;
		do_return <= r;
		@(posedge pclk);
		flags <= 18'h0;
		fire <= 1'b0;
		wr_prio <= 1'b0;
		do_return <= 1'b0;
		repeat (9) @(posedge pclk);
	endtask : poll
	// Highest level wins; natural order only breaks ties
	function automatic logic [6:0] win(input logic [17:0] fl);
		logic [6:0] b;
		logic [4:0] s;
		logic [1:0] l;
		logic       got;
		b = 7'h0;
		got = 1'b0;
		for (int k = 0; k < 18; k++)
		begin
			s = ips_pkg::NAT_ORDER[k];
			l = {hi[s], lo[s]};
			if (fl[s] && (!got || l > b[1:0]))
			begin
				b = {s, l};
				got = 1'b1;
			end
		end
		return b;
	endfunction : win
	function automatic logic [15:0] nx(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : nx
	task automatic summarize();
		$display("mismatches %0d checks %0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : summarize

	// ==========================================================
	// Main sequence
	initial
	begin
		{presetn, psel, penable, pwrite, fire, wr_prio, do_return} = '0;
		{paddr, pwdata, flags, lo, hi} = '0;
		lfsr = 16'h9bb0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		// Reset values, then writable bits only
		for (int i = 0; i < 12; i++)
		begin
			rdq.push_back(i < 6 ? 32'h0 : {24'h0, MSK[i % 6]});
			if (i == 6)
				for (int j = 0; j < 6; j++)
					apb(1'b1, ADR[j], 32'hffffffff, 1'b0);
			apb(1'b0, ADR[i % 6], 32'h0, 1'b0);
		end
		apb(1'b0, 12'h004, 32'h0, 1'b1);
		apb(1'b1, ips_pkg::ADDR_SERVICE_STATUS, 32'h0, 1'b1);
		// Random levels and flags, one call each, then a return
		repeat (14)
		begin
			lfsr = nx(lfsr);
			f[17:2] = lfsr;
			lfsr = nx(lfsr);
			setp({lfsr[1:0], f[17:2]}, {f[3:2], lfsr});
			lfsr = nx(lfsr);
			f = {lfsr[1:0], lfsr} | 18'h1;
			poll(f, 1'b1, 1'b0, 1'b0, 1'b1, win(f));
			poll(18'h0, 1'b1, 1'b0, 1'b1, 1'b0, 7'h0);
			check(32'(in_service), 32'h0, "busy");
		end
		// Nesting: base sources level 1, the rest level 3
		setp(18'h3ffff, 18'h3ff80);
		poll(18'h1, 1'b1, 1'b0, 1'b0, 1'b1, {5'd0, 2'd1});
		poll(18'h1, 1'b1, 1'b0, 1'b0, 1'b0, 7'h0);
		poll(18'h80, 1'b1, 1'b1, 1'b0, 1'b0, 7'h0);
		poll(18'h0, 1'b1, 1'b0, 1'b0, 1'b0, 7'h0);
		poll(18'h80, 1'b0, 1'b0, 1'b0, 1'b0, 7'h0);
		poll(18'h80, 1'b1, 1'b0, 1'b0, 1'b1, {5'd7, 2'd3});
		check(32'(in_service), 32'ha, "busy");
		poll(18'h0, 1'b1, 1'b0, 1'b0, 1'b0, 7'h0);
		check(32'(in_service), 32'ha, "busy");
		poll(18'h0, 1'b1, 1'b0, 1'b1, 1'b0, 7'h0);
		check(32'(in_service), 32'h2, "busy");
		poll(18'h80, 1'b1, 1'b0, 1'b1, 1'b0, 7'h0);
		check(32'(in_service), 32'h0, "busy");
		check(cq.size(), 32'h0, "queue");
		// Status view: idle, no call, nothing in service
		rdq.push_back(32'h0);
		apb(1'b0, ips_pkg::ADDR_SERVICE_STATUS, 32'h0, 1'b0);
		summarize();
	end
endmodule : interrupt_priority_service_bench
